// ==== common/rxcl_defs.vh ====
// Register offsets, field positions, reset values and bus responses for the receive channel latch bank
`ifndef RXCL_DEFS_VH
`define RXCL_DEFS_VH

// ----------------------------------------
// Register byte offsets (one word per channel group)
// ----------------------------------------
`define RXCL_STATIC0_C 8'h00
`define RXCL_STATIC1_C 8'h04
`define RXCL_DYNAMIC_C 8'h08
`define RXCL_STATIC0_D 8'h0C
`define RXCL_STATIC1_D 8'h10
`define RXCL_DYNAMIC_D 8'h14
`define RXCL_STATUS 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RXCL_RATE_BIT 0
`define RXCL_TRG_BIT 0
`define RXCL_PDET_LO 2
`define RXCL_SDET_LO 4
`define RXCL_ROE1_BIT 1
`define RXCL_ROE2_BIT 2
`define RXCL_BIST0_BIT 4
`define RXCL_RXEN_BIT 5
`define RXCL_BIST1_BIT 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RXCL_RATE_RST 1'h1
`define RXCL_DET_RST 2'h2
`define RXCL_TRG_RST 1'h0
`define RXCL_RXEN_RST 1'h0
`define RXCL_BIST_RST 2'h3
`define RXCL_ROE_RST 1'h0

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RXCL_RESP_OKAY 2'h0
`define RXCL_RESP_SLVERR 2'h2

`endif

// ==== tb/rxcl_host.sv ====
// Host controller model: AXI4-Lite master writing the latch bank
`timescale 1ns/1ps
`default_nettype none
module rxcl_host (
	input wire logic aclk,
	output var logic [7:0] s_axi_awaddr,
	output var logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output var logic [31:0] s_axi_wdata,
	output var logic [3:0] s_axi_wstrb,
	output var logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output var logic s_axi_bready,
	output var logic [7:0] s_axi_araddr,
	output var logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output var logic s_axi_rready
);
	// Idle bus from time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// Write one word; a released payload is inverted so stale values cannot pass
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] r);
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_awvalid <= 1'b1;
			s_axi_wdata <= v;
			s_axi_wstrb <= s;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_awready) begin
					s_axi_awvalid <= 1'b0;
					s_axi_awaddr <= ~a;
				end
				if (s_axi_wready) begin
					s_axi_wvalid <= 1'b0;
					s_axi_wdata <= ~v;
				end
			end while (!s_axi_bvalid);
			r = s_axi_bresp;
			s_axi_bready <= 1'b0;
		end
	endtask
	// Read one word
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_arready) begin
					s_axi_arvalid <= 1'b0;
					s_axi_araddr <= ~a;
				end
			end while (!s_axi_rvalid);
			v = s_axi_rdata;
			r = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/rxcl_latch_bank_assertions.sv ====
// Port-level checks for the receive channel latch bank
`timescale 1ns/1ps
`default_nettype none
module rxcl_latch_bank_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] rx_clock_rate_select,
	input wire logic [3:0] primary_detect_threshold,
	input wire logic [3:0] secondary_detect_threshold,
	input wire logic [1:0] primary_detector_enable,
	input wire logic [1:0] secondary_detector_enable,
	input wire logic [1:0] training_clock_multiplier,
	input wire logic [1:0] receive_channel_enable,
	input wire logic [3:0] receive_selftest_mode,
	input wire logic [1:0] selftest_active,
	input wire logic [1:0] reclock_primary_out_enable,
	input wire logic [1:0] reclock_secondary_out_enable,
	input wire logic [1:0] reclock_logic_power_down
);
	// ----
	// One clock domain, so clocking and disable are declared once
	// ----
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence resp_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	chk_pd_both_off: assert property (
		reclock_logic_power_down == ~(reclock_primary_out_enable | reclock_secondary_out_enable))
		else $error("logic power down disagrees with driver enables");
	chk_reset_init: assert property ($rose(aresetn) |->
		rx_clock_rate_select == 2'h3 && primary_detect_threshold == 4'hA && secondary_detect_threshold == 4'hA
		&& training_clock_multiplier == 2'h0 && receive_channel_enable == 2'h0 && receive_selftest_mode == 4'hF
		&& reclock_primary_out_enable == 2'h0 && reclock_secondary_out_enable == 2'h0)
		else $error("latch outputs not at initial values after reset");
	chk_latch_hold: assert property (
		!$stable({rx_clock_rate_select, primary_detect_threshold, secondary_detect_threshold,
		training_clock_multiplier, receive_channel_enable, receive_selftest_mode,
		reclock_primary_out_enable, reclock_secondary_out_enable})
		|-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
		else $error("latch output moved without a completed write");
	chk_det_primary: assert property (
		primary_detector_enable == {|primary_detect_threshold[3:2], |primary_detect_threshold[1:0]})
		else $error("primary detector enable wrong for code");
	chk_det_second: assert property (
		secondary_detector_enable == {|secondary_detect_threshold[3:2], |secondary_detect_threshold[1:0]})
		else $error("secondary detector enable wrong for code");
	chk_selftest_flag: assert property (
		selftest_active == {receive_selftest_mode[3:2] == 2'h2, receive_selftest_mode[1:0] == 2'h2})
		else $error("selftest active flag wrong for mode");
	chk_write_resp: assert property (wr_taken |=> s_axi_bvalid)
		else $error("no write response after handshake");
	chk_bresp_hold: assert property (resp_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before acceptance");
endmodule
`default_nettype wire

// ==== tb/rxcl_latch_bank_tb.sv ====
// Self-checking testbench for the receive channel latch bank
`timescale 1ns/1ps
`default_nettype none
`include "rxcl_defs.vh"
module rxcl_latch_bank_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [1:0] speed_range_select_pin = 2'h3;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, primary_detect_threshold, secondary_detect_threshold, receive_selftest_mode;
	logic [1:0] s_axi_bresp, s_axi_rresp, rx_clock_rate_select, primary_detector_enable, r;
	logic [1:0] secondary_detector_enable, training_clock_multiplier, receive_channel_enable, selftest_active;
	logic [1:0] reclock_primary_out_enable, reclock_secondary_out_enable, reclock_logic_power_down;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int failures = 0;
	int compares = 0;
	localparam logic [29:0] RST = {2'h3, 4'hA, 4'hA, 2'h3, 2'h3, 2'h0, 2'h0, 4'hF, 2'h0, 2'h0, 2'h0, 2'h3};
	wire logic [29:0] outs = {rx_clock_rate_select, primary_detect_threshold, secondary_detect_threshold,
		primary_detector_enable, secondary_detector_enable, training_clock_multiplier, receive_channel_enable,
		receive_selftest_mode, selftest_active, reclock_primary_out_enable, reclock_secondary_out_enable,
		reclock_logic_power_down};
	rxcl_latch_bank dut (.*);
	rxcl_host host (.*);
	// ----
	// Clock, watchdog, verdict
	// ----
	always #2.5 aclk = ~aclk;
	initial begin
		#50000;
		failures++;
		close_out();
	end
	task automatic close_out();
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Six cycles of reset, then let the first edges land
	task automatic apply_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		#1;
	endtask
	// Latch pins follow one edge after the response is raised, on the edge the host sees it, before the two-edge wait
	task automatic wrc(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] e);
		host.wr(a, v, s, r);
		cmp("bresp", e, r);
		repeat (2) @(posedge aclk);
		#1;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		host.rd(a, d, r);
		cmp("rdata", e, d);
		cmp("rresp", er, r);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		cmp("outs", RST, outs);
		rdc(`RXCL_STATIC0_C, 32'h1, `RXCL_RESP_OKAY);
		rdc(`RXCL_STATIC1_C, 32'h28, `RXCL_RESP_OKAY);
		rdc(`RXCL_DYNAMIC_D, 32'h50, `RXCL_RESP_OKAY);
	endtask
	// The host picks its capture edges from this select: alternate pair edges at half rate, true rise at full
	task automatic t_rate();
		wrc(`RXCL_STATIC0_C, 32'h0, 4'hF, `RXCL_RESP_OKAY);
		cmp("rate", 2'h2, rx_clock_rate_select);
		wrc(`RXCL_STATIC0_D, 32'h0, 4'hF, `RXCL_RESP_OKAY);
		wrc(`RXCL_STATIC0_C, 32'h1, 4'hF, `RXCL_RESP_OKAY);
		cmp("rate", 2'h1, rx_clock_rate_select);
	endtask
	// Every threshold code on both detectors; doubling only with speed pins high
	task automatic t_thr();
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wrc(`RXCL_STATIC1_C, {26'h0, ~c, c, 2'h1}, 4'h1, `RXCL_RESP_OKAY);
			cmp("pthr", {2'h2, c}, primary_detect_threshold);
			cmp("sthr", {2'h2, ~c}, secondary_detect_threshold);
			cmp("pdet", {1'b1, |c}, primary_detector_enable);
			cmp("sdet", {1'b1, |(~c)}, secondary_detector_enable);
			cmp("trg", 2'h1, training_clock_multiplier);
		end
		rdc(`RXCL_STATIC1_C, 32'h0D, `RXCL_RESP_OKAY);
	endtask
	// Driver enable pairs, receive enable and the two legal selftest codes
	task automatic t_dyn();
		logic [7:0] v;
		logic [7:0] tbl [4] = '{8'h32, 8'h64, 8'h16, 8'h60};
		for (int i = 0; i < 4; i++) begin
			v = tbl[i];
			wrc(`RXCL_DYNAMIC_D, {24'h0, v}, 4'h1, `RXCL_RESP_OKAY);
			cmp("roe1", {v[1], 1'b0}, reclock_primary_out_enable);
			cmp("roe2", {v[2], 1'b0}, reclock_secondary_out_enable);
			cmp("pdown", {~(v[1] | v[2]), 1'b1}, reclock_logic_power_down);
			cmp("rxen", {v[5], 1'b0}, receive_channel_enable);
			cmp("bist", {v[6], v[4], 2'h3}, receive_selftest_mode);
			cmp("bact", {v[6] & ~v[4], 1'b0}, selftest_active);
			rdc(`RXCL_DYNAMIC_D, {24'h0, v & 8'h76}, `RXCL_RESP_OKAY);
		end
	endtask
	// Refused and masked writes change nothing
	task automatic t_err();
		logic [29:0] keep;
		keep = outs;
		wrc(8'h1C, 32'hFF, 4'hF, `RXCL_RESP_SLVERR);
		wrc(`RXCL_STATUS, 32'hFF, 4'hF, `RXCL_RESP_SLVERR);
		wrc(`RXCL_DYNAMIC_D, 32'h0, 4'h0, `RXCL_RESP_OKAY);
		cmp("outs", keep, outs);
		rdc(8'h1C, 32'h0, `RXCL_RESP_SLVERR);
		@(posedge aclk);
		speed_range_select_pin <= 2'h1;
		repeat (8) @(posedge aclk);
		// Doubling stays on channel C only, whose speed pin is still high, so no reserved flag
		rdc(`RXCL_STATUS, 32'h31, `RXCL_RESP_OKAY);
		cmp("speed", 2'h1, d[1:0]);
	endtask
	initial begin
		apply_reset();
		t_reset();
		t_rate();
		t_thr();
		t_dyn();
		t_err();
		apply_reset();
		t_reset();
		close_out();
	end
endmodule
bind rxcl_latch_bank rxcl_latch_bank_assertions u_chk (.*);
`default_nettype wire

// ==== verilog/rxcl_latch_bank.v ====
// Receive and reclocker channel configuration latches behind an AXI4-Lite slave
// Notes on behaviour
// - Rate one: receive clock pair at half rate
// - Rate zero: receive clock pair at full rate
// - Primary detect select two bits, resets 10
// - Code 00 disables detector, others set thresholds
// - Secondary detect select same encoding, resets 10
// - Training multiplier resets 0; one doubles clock
// - Receive enable resets 0; zero powers down
// - Selftest 01 video, 10 selftest with video
// - Secondary reclock enable resets 0, gates driver
// - Primary reclock enable resets 0, gates driver
// - Both drivers off powers down channel logic
// - Reset disables every serial output driver
// - Receive clock rate resets to half rate
`timescale 1ns/1ps
`default_nettype none
`include "rxcl_defs.vh"

module rxcl_latch_bank (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] speed_range_select_pin,
	output reg [1:0] rx_clock_rate_select,
	output reg [3:0] primary_detect_threshold,
	output reg [3:0] secondary_detect_threshold,
	output reg [1:0] primary_detector_enable,
	output reg [1:0] secondary_detector_enable,
	output reg [1:0] training_clock_multiplier,
	output reg [1:0] receive_channel_enable,
	output reg [3:0] receive_selftest_mode,
	output reg [1:0] selftest_active,
	output reg [1:0] reclock_primary_out_enable,
	output reg [1:0] reclock_secondary_out_enable,
	output reg [1:0] reclock_logic_power_down
);

	// ----------------------------------------
	// Latch storage, index 0 is channel C, index 1 is channel D
	// ----------------------------------------
	reg [1:0] rate_q;
	reg [3:0] pdet_q;
	reg [3:0] sdet_q;
	reg [1:0] trg_q;
	reg [1:0] rxen_q;
	reg [3:0] bist_q;
	reg [1:0] roe1_q;
	reg [1:0] roe2_q;
	reg [1:0] bad_combo_q;

	// Write channel state
	reg aw_held_q;
	reg w_held_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;

	// Speed select pins pass three flops; a change counts once stages two and three agree
	reg [1:0] spd_s1_q;
	reg [1:0] spd_s2_q;
	reg [1:0] spd_s3_q;
	reg [1:0] spd_q;

	wire aw_ok = aw_held_q | s_axi_awvalid;
	wire w_ok = w_held_q | s_axi_wvalid;
	wire [7:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
	wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
	wire do_write = aw_ok & w_ok & ~s_axi_bvalid;
	// Every field sits in byte lane 0, so only strobe bit 0 matters
	wire lane0 = wr_strb[0];

	// Address decode shared by the read and write paths
	function [2:0] rxcl_decode;
		input [7:0] addr;
		begin
			if (addr == `RXCL_STATIC0_C) begin
				rxcl_decode = 3'h0;
			end else if (addr == `RXCL_STATIC1_C) begin
				rxcl_decode = 3'h1;
			end else if (addr == `RXCL_DYNAMIC_C) begin
				rxcl_decode = 3'h2;
			end else if (addr == `RXCL_STATIC0_D) begin
				rxcl_decode = 3'h3;
			end else if (addr == `RXCL_STATIC1_D) begin
				rxcl_decode = 3'h4;
			end else if (addr == `RXCL_DYNAMIC_D) begin
				rxcl_decode = 3'h5;
			end else if (addr == `RXCL_STATUS) begin
				rxcl_decode = 3'h6;
			end else begin
				rxcl_decode = 3'h7;
			end
		end
	endfunction

	// Decoded selects; code 6 is the status word and code 7 is unmapped
	wire [2:0] wsel = rxcl_decode(wr_addr);
	wire [2:0] rsel = rxcl_decode(s_axi_araddr);
	wire wr_hit_ch = (wsel == 3'h3) | (wsel == 3'h4) | (wsel == 3'h5);
	wire wr_ch = wr_hit_ch;
	wire [1:0] wr_kind = (wsel == 3'h0 || wsel == 3'h3) ? 2'h0 : (wsel == 3'h1 || wsel == 3'h4) ? 2'h1 : 2'h2;
	wire wr_mapped = (wsel != 3'h7) & (wsel != 3'h6);

	// ----------------------------------------
	// Channel merge helper
	// ----------------------------------------
	// One-bit latches of both channels share a vector, so a write must touch only the addressed slot
	function [1:0] rxcl_merge;
		input [1:0] old;
		input [1:0] mask;
		input val;
		begin
			rxcl_merge = (old & ~mask) | (mask & {2{val}});
		end
	endfunction

	// ----------------------------------------
	// Write address and data capture, either order
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RXCL_RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_awvalid && !aw_held_q && !s_axi_awready && !s_axi_bvalid) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && !w_held_q && !s_axi_wready && !s_axi_bvalid) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b1;
			end
			// Commit only once both halves are registered, so readies stay one-cycle pulses
			if (aw_held_q && w_held_q && !s_axi_bvalid) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `RXCL_RESP_OKAY : `RXCL_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// A cleared lane strobe or an unmapped offset still answers but leaves every latch alone
	wire commit = do_write & aw_held_q & w_held_q & wr_mapped & lane0;
	wire [1:0] cm = wr_ch ? 2'b10 : 2'b01;

	// ----------------------------------------
	// Configuration latches
	// ----------------------------------------
	// Each latch keeps its value until rewritten or reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			// Power-up values: half-rate clock, mid thresholds, receiver off, drivers off
			rate_q <= {2{`RXCL_RATE_RST}};
			pdet_q <= {2{`RXCL_DET_RST}};
			sdet_q <= {2{`RXCL_DET_RST}};
			trg_q <= {2{`RXCL_TRG_RST}};
			rxen_q <= {2{`RXCL_RXEN_RST}};
			bist_q <= {2{`RXCL_BIST_RST}};
			roe1_q <= {2{`RXCL_ROE_RST}};
			roe2_q <= {2{`RXCL_ROE_RST}};
		end else if (commit) begin
			if (wr_kind == 2'h0) begin
				rate_q <= rxcl_merge(rate_q, cm, w_data_q[`RXCL_RATE_BIT]);
			end else if (wr_kind == 2'h1) begin
				trg_q <= rxcl_merge(trg_q, cm, w_data_q[`RXCL_TRG_BIT]);
				if (wr_ch) begin
					pdet_q[3:2] <= w_data_q[`RXCL_PDET_LO+1:`RXCL_PDET_LO];
					sdet_q[3:2] <= w_data_q[`RXCL_SDET_LO+1:`RXCL_SDET_LO];
				end else begin
					pdet_q[1:0] <= w_data_q[`RXCL_PDET_LO+1:`RXCL_PDET_LO];
					sdet_q[1:0] <= w_data_q[`RXCL_SDET_LO+1:`RXCL_SDET_LO];
				end
			end else begin
				rxen_q <= rxcl_merge(rxen_q, cm, w_data_q[`RXCL_RXEN_BIT]);
				roe1_q <= rxcl_merge(roe1_q, cm, w_data_q[`RXCL_ROE1_BIT]);
				roe2_q <= rxcl_merge(roe2_q, cm, w_data_q[`RXCL_ROE2_BIT]);
				// Selftest codes 00 and 11 pass through as written; avoiding them is the host's duty
				if (wr_ch) begin
					bist_q[3:2] <= {w_data_q[`RXCL_BIST1_BIT], w_data_q[`RXCL_BIST0_BIT]};
				end else begin
					bist_q[1:0] <= {w_data_q[`RXCL_BIST1_BIT], w_data_q[`RXCL_BIST0_BIT]};
				end
			end
		end
	end

	// ----------------------------------------
	// Speed select synchroniser and reserved-combination flag
	// ----------------------------------------
	// The flag only reports a host slip; the doubled setting is still passed on as written
	// The held speed flips only once both late stages agree, so a one-cycle glitch never counts
	always @(posedge aclk) begin
		if (!aresetn) begin
			spd_s1_q <= 2'b00;
			spd_s2_q <= 2'b00;
			spd_s3_q <= 2'b00;
			spd_q <= 2'b00;
			bad_combo_q <= 2'b00;
		end else begin
			spd_s1_q <= speed_range_select_pin;
			spd_s2_q <= spd_s1_q;
			spd_s3_q <= spd_s2_q;
			spd_q <= (spd_s2_q & spd_s3_q) | (spd_q & (spd_s2_q | spd_s3_q));
			bad_combo_q <= trg_q & ~spd_q;
		end
	end

	// ----------------------------------------
	// Registered control outputs
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_clock_rate_select <= {2{`RXCL_RATE_RST}};
			primary_detect_threshold <= {2{`RXCL_DET_RST}};
			secondary_detect_threshold <= {2{`RXCL_DET_RST}};
			primary_detector_enable <= 2'b11;
			secondary_detector_enable <= 2'b11;
			training_clock_multiplier <= 2'b00;
			receive_channel_enable <= 2'b00;
			receive_selftest_mode <= {2{`RXCL_BIST_RST}};
			selftest_active <= 2'b00;
			// Reset forces every serial driver off regardless of latch contents
			reclock_primary_out_enable <= 2'b00;
			reclock_secondary_out_enable <= 2'b00;
			reclock_logic_power_down <= 2'b11;
		end else begin
			// One selects half rate, zero full rate for the recovered clock pair
			rx_clock_rate_select <= rate_q;
			primary_detect_threshold <= pdet_q;
			secondary_detect_threshold <= sdet_q;
			// Code 00 turns the analog detector off
			primary_detector_enable <= {|pdet_q[3:2], |pdet_q[1:0]};
			secondary_detector_enable <= {|sdet_q[3:2], |sdet_q[1:0]};
			training_clock_multiplier <= trg_q;
			receive_channel_enable <= rxen_q;
			receive_selftest_mode <= bist_q;
			// Only code 10 runs selftest; 01 is plain video reception
			selftest_active <= {bist_q[3:2] == 2'b10, bist_q[1:0] == 2'b10};
			reclock_primary_out_enable <= roe1_q;
			reclock_secondary_out_enable <= roe2_q;
			// A channel with both drivers off also sleeps its reclock logic
			reclock_logic_power_down <= ~(roe1_q | roe2_q);
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	// Latches are write-only on the device, so readback mirrors them for software
	reg [31:0] rd_word;
	always @* begin
		rd_word = 32'h0000_0000;
		if (rsel == 3'h0) begin
			rd_word[`RXCL_RATE_BIT] = rate_q[0];
		end else if (rsel == 3'h1) begin
			rd_word[`RXCL_TRG_BIT] = trg_q[0];
			rd_word[`RXCL_PDET_LO+1:`RXCL_PDET_LO] = pdet_q[1:0];
			rd_word[`RXCL_SDET_LO+1:`RXCL_SDET_LO] = sdet_q[1:0];
		end else if (rsel == 3'h2) begin
			rd_word[`RXCL_ROE1_BIT] = roe1_q[0];
			rd_word[`RXCL_ROE2_BIT] = roe2_q[0];
			rd_word[`RXCL_BIST0_BIT] = bist_q[0];
			rd_word[`RXCL_RXEN_BIT] = rxen_q[0];
			rd_word[`RXCL_BIST1_BIT] = bist_q[1];
		end else if (rsel == 3'h3) begin
			rd_word[`RXCL_RATE_BIT] = rate_q[1];
		end else if (rsel == 3'h4) begin
			rd_word[`RXCL_TRG_BIT] = trg_q[1];
			rd_word[`RXCL_PDET_LO+1:`RXCL_PDET_LO] = pdet_q[3:2];
			rd_word[`RXCL_SDET_LO+1:`RXCL_SDET_LO] = sdet_q[3:2];
		end else if (rsel == 3'h5) begin
			rd_word[`RXCL_ROE1_BIT] = roe1_q[1];
			rd_word[`RXCL_ROE2_BIT] = roe2_q[1];
			rd_word[`RXCL_BIST0_BIT] = bist_q[2];
			rd_word[`RXCL_RXEN_BIT] = rxen_q[1];
			rd_word[`RXCL_BIST1_BIT] = bist_q[3];
		end else if (rsel == 3'h6) begin
			rd_word[7:0] = {2'b00, reclock_logic_power_down, bad_combo_q, spd_q};
		end
	end

	// One read in flight; data are raised only after the address handshake, never alongside it
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RXCL_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rsel == 3'h7) ? `RXCL_RESP_SLVERR : `RXCL_RESP_OKAY;
			end else if (s_axi_arready) begin
				// Address taken at this edge
				s_axi_rvalid <= 1'b1;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire
